// >>> tb/lbp_arbiter_sva.sv
module lbp_arbiter_chk (
    // clocking
    input wire logic core_clk,
    input wire logic resetn,
    // watched pins
    input wire logic eu_xfer_soon,
    input wire logic nmi,
    input wire lbp_pkg::lbp_grant_type unit_grant,
    input wire logic op_done,
    input wire logic halted,
    input wire logic shut_down,
    input wire logic bus_grant_out,
    input wire logic status_1_n,
    input wire logic status_0_n,
    input wire logic code_or_ack_n,
    input wire logic mem_not_io,
    input wire logic addr_bit_1,
    input wire logic addr_oe,
    input wire logic bus_exclusive_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic [3:0] st;
    logic ack1;
    logic ack2;
    logic hlt;
    assign st = {status_1_n, status_0_n, code_or_ack_n, mem_not_io};
    // the second acknowledge is told apart by its floating address
    assign ack1 = st == 4'h0 && addr_oe;
    assign ack2 = st == 4'h0 && !addr_oe;
    assign hlt = st == 4'h1;
    property p_lock1; ack1 |-> !bus_exclusive_n; endproperty
    a_lock1: assert property (p_lock1) else $error("ack not locked");
    property p_float; ack2 |-> ##1 !addr_oe; endproperty
    a_float: assert property (p_float) else $error("addr early");
    property p_drive; ack2 |-> ##[2:3] addr_oe; endproperty
    a_drive: assert property (p_drive) else $error("addr late");
    property p_gap; ack1 |-> ##1 (st == 4'hF) [*4]; endproperty
    a_gap: assert property (p_gap) else $error("ack gap short");
    property p_nohold; ack1 |-> ##1 !bus_grant_out [*8]; endproperty
    a_nohold: assert property (p_nohold) else $error("hold in ack");
    property p_onehot; $onehot0(unit_grant); endproperty
    a_onehot: assert property (p_onehot) else $error("two grants");
    property p_hdone; hlt |-> ##[1:3] op_done; endproperty
    a_hdone: assert property (p_hdone) else $error("halt hangs");
    property p_shut; hlt && !addr_bit_1 |-> ##[1:3] shut_down; endproperty
    a_shut: assert property (p_shut) else $error("no shutdown");
    property p_pf; eu_xfer_soon |-> ##1 !unit_grant.pf [*3]; endproperty
    a_pf: assert property (p_pf) else $error("prefetch early");
    property p_nmi; $rose(nmi) |-> ##[1:6] !halted && !shut_down; endproperty
    a_nmi: assert property (p_nmi) else $error("nmi ignored");
    property p_hold; bus_grant_out |-> st == 4'hF; endproperty
    a_hold: assert property (p_hold) else $error("op in hold");
    c_ack: cover property (ack2);
    c_halt: cover property (hlt && addr_bit_1);
    c_hold: cover property ($rose(bus_grant_out));
endmodule

bind lbp_arbiter lbp_arbiter_chk lbp_arbiter_chk_i (
    .core_clk(core_clk), .resetn(resetn), .eu_xfer_soon(eu_xfer_soon),
    .nmi(nmi), .unit_grant(unit_grant), .op_done(op_done),
    .halted(halted), .shut_down(shut_down), .bus_grant_out(bus_grant_out),
    .status_1_n(status_1_n), .status_0_n(status_0_n),
    .code_or_ack_n(code_or_ack_n), .mem_not_io(mem_not_io),
    .addr_bit_1(addr_bit_1), .addr_oe(addr_oe),
    .bus_exclusive_n(bus_exclusive_n)
);

// >>> tb/lbp_ready_model.sv
module lbp_ready_model (
    // clocking
    input wire logic core_clk,
    input wire logic resetn,
    // bus state seen by the ready logic
    input wire lbp_pkg::lbp_stat_type stat,
    input wire logic op_done,
    // ready back to the device
    output logic ready_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy_reg;
    logic [1:0] wait_reg;
    // halt and shutdown are never latched, so they never get ready
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            busy_reg <= 1'h0;
            wait_reg <= 2'h0;
        end else if (op_done) begin
            busy_reg <= 1'h0;
        end else if (stat != lbp_pkg::STAT_IDLE &&
                     stat != lbp_pkg::STAT_HALT) begin
            busy_reg <= 1'h1;
            wait_reg <= 2'h1;
        end else if (wait_reg != 2'h0) begin
            wait_reg <= wait_reg - 2'h1;
        end
    end
    // held low until the operation completes; pulled high between
    assign ready_n = !(busy_reg && wait_reg == 2'h0);
endmodule

// >>> tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'h0;
    logic resetn = 1'h0;
    lbp_pkg::lbp_req_type unit_req = '0;
    lbp_pkg::lbp_wr_type unit_wr = '0;
    logic eu_xfer_soon = 1'h0;
    logic halt_instr = 1'h0;
    logic multi_fault = 1'h0;
    logic cop_overrun = 1'h0;
    logic irq_enabled = 1'h0;
    logic hold_req = 1'h0;
    logic coproc_operand_req = 1'h0;
    logic nmi = 1'h0;
    logic maskable_irq = 1'h0;
    logic ready_n;
    lbp_pkg::lbp_grant_type unit_grant;
    logic op_done, halted, shut_down, bus_grant_out, addr_bit_1, addr_oe;
    logic status_1_n, status_0_n, code_or_ack_n, mem_not_io;
    logic bus_exclusive_n;
    lbp_pkg::lbp_stat_type stat;
    lbp_pkg::lbp_grant_type g;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    assign stat = {status_1_n, status_0_n, code_or_ack_n, mem_not_io};
    always #10 core_clk = !core_clk;

    lbp_arbiter lbp_arbiter_i (
        .core_clk(core_clk), .resetn(resetn), .ce(1'h1),
        .unit_req(unit_req), .unit_wr(unit_wr), .eu_xfer_soon(eu_xfer_soon),
        .halt_instr(halt_instr), .multi_fault(multi_fault),
        .cop_overrun(cop_overrun), .irq_enabled(irq_enabled),
        .hold_req(hold_req), .coproc_operand_req(coproc_operand_req),
        .nmi(nmi), .maskable_irq(maskable_irq), .ready_n(ready_n),
        .unit_grant(unit_grant), .op_done(op_done), .halted(halted),
        .shut_down(shut_down), .bus_grant_out(bus_grant_out),
        .status_1_n(status_1_n), .status_0_n(status_0_n),
        .code_or_ack_n(code_or_ack_n), .mem_not_io(mem_not_io),
        .addr_bit_1(addr_bit_1), .addr_oe(addr_oe),
        .upper_byte_enable_oe(), .bus_exclusive_n(bus_exclusive_n),
        .bus_exclusive_oe()
    );
    lbp_ready_model lbp_ready_model_i (
        .core_clk(core_clk), .resetn(resetn), .stat(stat),
        .op_done(op_done), .ready_n(ready_n)
    );

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // bounded so a stuck bus still reaches the report
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [6:0] e,
                       input logic [6:0] got);
        n_tests++;
        if (got !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", what, e, got);
        end
    endtask
    // waits for a status state, then withdraws the granted request
    task automatic next_op(output lbp_pkg::lbp_grant_type g);
        for (int i = 0; i < 40 && stat === lbp_pkg::STAT_IDLE; i++) tick(1);
        g = unit_grant;
        unit_req &= ~{g[6:3], g[1:0]};
    endtask
    task automatic hold_cycle();
        hold_req = 1'h1;
        for (int i = 0; i < 40 && bus_grant_out !== 1'h1; i++) tick(1);
        chk("bus_grant_out", 7'h1, 7'(bus_grant_out));
        hold_req = 1'h0;
        for (int i = 0; i < 40 && bus_grant_out !== 1'h0; i++) tick(1);
    endtask
    task automatic t_prio();
        logic [6:0] want [5] = '{7'h20, 7'h10, 7'h08, 7'h02, 7'h01};
        unit_wr = 5'h01;
        unit_req = 6'h1F;
        foreach (want[i]) begin
            next_op(g);
            chk("grant", want[i], g);
            tick(1);
        end
    endtask
    task automatic t_hold();
        unit_req.lock = 1'h1;
        next_op(g);
        hold_req = 1'h1;
        coproc_operand_req = 1'h1;
        unit_req.eu = 1'h1;
        for (int i = 0; i < 40 && bus_grant_out !== 1'h1; i++) tick(1);
        chk("bus_grant_out", 7'h1, 7'(bus_grant_out));
        hold_req = 1'h0;
        next_op(g);
        chk("grant", 7'h04, g);
        coproc_operand_req = 1'h0;
        tick(1);
        next_op(g);
        chk("grant", 7'h02, g);
        tick(1);
    endtask
    task automatic t_ack();
        unit_req.ack = 1'h1;
        next_op(g);
        chk("grant", 7'h40, g);
        chk("status", 7'(lbp_pkg::STAT_ACK), 7'(stat));
        hold_req = 1'h1;
        tick(1);
        next_op(g);
        chk("status", 7'(lbp_pkg::STAT_ACK), 7'(stat));
        chk("addr_oe", 7'h0, 7'(addr_oe));
        chk("bus_grant_out", 7'h0, 7'(bus_grant_out));
        hold_cycle();
    endtask
    task automatic t_pf();
        eu_xfer_soon = 1'h1;
        unit_req.pf = 1'h1;
        tick(4);
        eu_xfer_soon = 1'h0;
        next_op(g);
        chk("grant", 7'h01, g);
        tick(4);
    endtask
    task automatic t_halt();
        halt_instr = 1'h1;
        tick(1);
        halt_instr = 1'h0;
        next_op(g);
        chk("status", 7'(lbp_pkg::STAT_HALT), 7'(stat));
        chk("addr_bit_1", 7'(lbp_pkg::ADDR1_HALT), 7'(addr_bit_1));
        tick(2);
        chk("halted", 7'h1, 7'(halted));
        hold_cycle();
        irq_enabled = 1'h1;
        maskable_irq = 1'h1;
        tick(8);
        chk("halted", 7'h0, 7'(halted));
        maskable_irq = 1'h0;
        irq_enabled = 1'h0;
        tick(6);
    endtask
    task automatic t_shut();
        logic seen = 1'h0;
        multi_fault = 1'h1;
        tick(1);
        multi_fault = 1'h0;
        next_op(g);
        chk("status", 7'(lbp_pkg::STAT_HALT), 7'(stat));
        chk("addr_bit_1", 7'(lbp_pkg::ADDR1_SHUT), 7'(addr_bit_1));
        tick(2);
        irq_enabled = 1'h1;
        maskable_irq = 1'h1;
        cop_overrun = 1'h1;
        tick(1);
        cop_overrun = 1'h0;
        coproc_operand_req = 1'h1;
        repeat (12) begin
            tick(1);
            seen |= unit_grant.cop_new;
        end
        chk("cop_new", 7'h0, 7'(seen));
        chk("shut_down", 7'h1, 7'(shut_down));
        maskable_irq = 1'h0;
        irq_enabled = 1'h0;
        nmi = 1'h1;
        tick(8);
        chk("shut_down", 7'h0, 7'(shut_down));
        nmi = 1'h0;
        next_op(g);
        chk("grant", 7'h04, g);
        coproc_operand_req = 1'h0;
        tick(8);
    endtask

    initial begin
        tick(10);
        resetn = 1'h1;
        tick(1);
        chk("status", 7'(lbp_pkg::STAT_IDLE), 7'(stat));
        chk("bus_exclusive_n", 7'h1, 7'(bus_exclusive_n));
        t_prio();
        t_hold();
        t_ack();
        t_pf();
        t_halt();
        t_shut();
        wrap_up();
    end
endmodule

// >>> verilog/lbp_arbiter.sv
// Contract
// - locked transfers, acknowledge included, rank first
// - odd-address second byte ranks second
// - coprocessor second or third cycle third
// - external hold request ranks fourth
// - new coprocessor operand request ranks fifth
// - execution unit data transfers rank sixth
// - prefetch last, inhibited two clocks early
// - halt instruction halts, multiple faults shut down
// - halt operation drives status low, mio high
// - addr_bit_1 high for halt, low shutdown
// - halted device still serves hold and coprocessor
// - overrun in shutdown stops coprocessor service
// - nmi or reset ends halt and shutdown
// - enabled irq or overrun ends halt only
// - second ack waits; address floats first
// - bus_exclusive_n asserted in first ack
// - address driven again in second command state
// - next address driven during status state
// - idle state after write before hold grant
// - no hold grant between acknowledge operations
// - three idle clocks between acknowledge operations
module lbp_arbiter (
    // clocking
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ce,
    // internal requesters
    input wire lbp_pkg::lbp_req_type unit_req,
    input wire lbp_pkg::lbp_wr_type unit_wr,
    input wire logic eu_xfer_soon,
    // core events
    input wire logic halt_instr,
    input wire logic multi_fault,
    input wire logic cop_overrun,
    input wire logic irq_enabled,
    // pins from the outside
    input wire logic hold_req,
    input wire logic coproc_operand_req,
    input wire logic nmi,
    input wire logic maskable_irq,
    input wire logic ready_n,
    // grants back to units
    output lbp_pkg::lbp_grant_type unit_grant,
    output logic op_done,
    output logic halted,
    output logic shut_down,
    // bus pins
    output logic bus_grant_out,
    output logic status_1_n,
    output logic status_0_n,
    output logic code_or_ack_n,
    output logic mem_not_io,
    output logic addr_bit_1,
    output logic addr_oe,
    output logic upper_byte_enable_oe,
    output logic bus_exclusive_n,
    output logic bus_exclusive_oe
);
    typedef enum {
        S_IDLE, S_TS, S_TC, S_GAP, S_POSTW, S_HOLD, S_HALTOP
    } lbp_state_type;
    lbp_state_type st_reg;
    lbp_pkg::lbp_op_type op_reg, sel;
    lbp_pkg::lbp_stat_type stat_reg;
    logic [4:0] pins, pins_s;
    logic hold_s, cop_s, nmi_s, irq_s, rdy_s;
    logic halt_reg, shut_reg, halt_pend_reg, shut_pend_reg, cop_block_reg;
    logic ack_busy_reg, wr_reg, tc_first_reg, run, done, exit_all, exit_halt;
    logic [1:0] gap_reg, pf_inh_reg;
    function automatic logic op_write(
        input lbp_pkg::lbp_op_type op,
        input lbp_pkg::lbp_wr_type wr
    );
        case (op)
            lbp_pkg::LBP_OP_LOCK: return wr.lock;
            lbp_pkg::LBP_OP_ODD2: return wr.odd2;
            lbp_pkg::LBP_OP_COP2: return wr.cop2;
            lbp_pkg::LBP_OP_COP: return wr.cop_new;
            lbp_pkg::LBP_OP_EU: return wr.eu;
            default: return 1'b0;
        endcase
    endfunction
    function automatic lbp_pkg::lbp_stat_type op_stat(
        input lbp_pkg::lbp_op_type op,
        input logic wr
    );
        case (op)
            lbp_pkg::LBP_OP_ACK1,
            lbp_pkg::LBP_OP_ACK2: return lbp_pkg::STAT_ACK;
            lbp_pkg::LBP_OP_PF: return lbp_pkg::STAT_CODE;
            default: return wr ? lbp_pkg::STAT_DWR : lbp_pkg::STAT_DRD;
        endcase
    endfunction
    assign pins = {ready_n, nmi, maskable_irq, coproc_operand_req, hold_req};
    lbp_sync #(.WIDTH(5), .INIT(lbp_pkg::PIN_INIT)) u_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .ce(ce),
        .d(pins),
        .q(pins_s)
    );
    assign rdy_s = !pins_s[lbp_pkg::PIN_READY_N];
    assign nmi_s = pins_s[lbp_pkg::PIN_NMI];
    assign irq_s = pins_s[lbp_pkg::PIN_IRQ];
    assign cop_s = pins_s[lbp_pkg::PIN_COP];
    assign hold_s = pins_s[lbp_pkg::PIN_HOLD];
    assign {status_1_n, status_0_n, code_or_ack_n, mem_not_io} = stat_reg;
    // only hold, coprocessor and odd-address second-byte traffic runs while halted
    assign run = !halt_reg && !shut_reg && !halt_pend_reg
                 && !shut_pend_reg;
    assign exit_all = nmi_s;
    assign exit_halt = (irq_s && irq_enabled) || cop_overrun;
    always_comb begin
        sel = lbp_pkg::LBP_OP_NONE;
        if (unit_req.ack && run && !ack_busy_reg) begin
            sel = lbp_pkg::LBP_OP_ACK1;
        end else if (unit_req.lock && run) begin
            sel = lbp_pkg::LBP_OP_LOCK;
        end else if (unit_req.odd2) begin
            sel = lbp_pkg::LBP_OP_ODD2;
        end else if (unit_req.cop2) begin
            sel = lbp_pkg::LBP_OP_COP2;
        end else if (hold_s && !ack_busy_reg) begin
            sel = lbp_pkg::LBP_OP_HOLD;
        end else if (cop_s && !cop_block_reg) begin
            sel = lbp_pkg::LBP_OP_COP;
        end else if (unit_req.eu && run) begin
            sel = lbp_pkg::LBP_OP_EU;
        end else if (unit_req.pf && run && !eu_xfer_soon
                     && pf_inh_reg == '0) begin
            sel = lbp_pkg::LBP_OP_PF;
        end
    end
    // second acknowledge holds off ready in its first command state
    assign done = st_reg == S_TC && rdy_s
                  && !(op_reg == lbp_pkg::LBP_OP_ACK2
                       && tc_first_reg);
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pf_inh_reg <= '0;
        end else if (ce) begin
            if (eu_xfer_soon) begin
                pf_inh_reg <= 2'(lbp_pkg::PF_INHIBIT_CLKS);
            end else if (pf_inh_reg != '0) begin
                pf_inh_reg <= pf_inh_reg - 2'h1;
            end
        end
    end
    // bus sequencer
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= S_IDLE;
            op_reg <= lbp_pkg::LBP_OP_NONE;
            wr_reg <= 1'b0;
            gap_reg <= '0;
            tc_first_reg <= 1'b0;
        end else if (ce) begin
            case (st_reg)
                S_IDLE: begin
                    if (halt_pend_reg || shut_pend_reg) begin
                        st_reg <= S_HALTOP;
                    end else if (sel == lbp_pkg::LBP_OP_HOLD) begin
                        st_reg <= S_HOLD;
                    end else if (sel != lbp_pkg::LBP_OP_NONE) begin
                        st_reg <= S_TS;
                        op_reg <= sel;
                        wr_reg <= op_write(sel, unit_wr);
                    end
                end
                S_TS: begin
                    st_reg <= S_TC;
                    tc_first_reg <= 1'b1;
                end
                S_TC: begin
                    tc_first_reg <= 1'b0;
                    if (done) begin
                        if (op_reg == lbp_pkg::LBP_OP_ACK1) begin
                            st_reg <= S_GAP;
                            gap_reg <= 2'(lbp_pkg::ACK_GAP_CLKS - 1);
                        end else if (wr_reg && hold_s && !ack_busy_reg) begin
                            st_reg <= S_POSTW;
                        end else begin
                            st_reg <= S_IDLE;
                        end
                    end
                end
                S_GAP: begin
                    if (gap_reg == '0) begin
                        st_reg <= S_TS;
                        op_reg <= lbp_pkg::LBP_OP_ACK2;
                        wr_reg <= 1'b0;
                    end else begin
                        gap_reg <= gap_reg - 2'h1;
                    end
                end
                S_POSTW: begin
                    st_reg <= S_HOLD;
                end
                S_HOLD: begin
                    if (!hold_s) begin
                        st_reg <= S_IDLE;
                    end
                end
                S_HALTOP: begin
                    st_reg <= S_IDLE;
                end
                default: begin
                    st_reg <= S_IDLE;
                end
            endcase
        end
    end
    // acknowledge pair keeps hold out until the second one ends
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ack_busy_reg <= 1'b0;
        end else if (ce) begin
            if (st_reg == S_IDLE && sel == lbp_pkg::LBP_OP_ACK1) begin
                ack_busy_reg <= 1'b1;
            end else if (done && op_reg == lbp_pkg::LBP_OP_ACK2) begin
                ack_busy_reg <= 1'b0;
            end
        end
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            {halt_pend_reg, shut_pend_reg, halt_reg, shut_reg} <= '0;
        end else if (ce) begin
            if (exit_all) begin
                {halt_pend_reg, shut_pend_reg, halt_reg, shut_reg} <= '0;
            end else if (multi_fault) begin
                shut_pend_reg <= 1'b1;
                halt_pend_reg <= 1'b0;
                halt_reg <= 1'b0;
            end else if (halt_instr && !shut_reg && !shut_pend_reg) begin
                halt_pend_reg <= 1'b1;
            end else if (st_reg == S_HALTOP) begin
                {halt_reg, shut_reg} <= {halt_pend_reg, shut_pend_reg};
                {halt_pend_reg, shut_pend_reg} <= '0;
            end else if (exit_halt && halt_reg) begin
                halt_reg <= 1'b0;
            end
        end
    end
    // coprocessor service stops after an overrun in shutdown
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cop_block_reg <= 1'b0;
        end else if (ce) begin
            if (cop_overrun && shut_reg) begin
                cop_block_reg <= 1'b1;
            end else if (exit_all) begin
                cop_block_reg <= 1'b0;
            end
        end
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            unit_grant <= '0;
            op_done <= 1'b0;
        end else if (ce) begin
            unit_grant <= '0;
            op_done <= done || st_reg == S_HALTOP;
            if (st_reg == S_IDLE && !halt_pend_reg
                && !shut_pend_reg) begin
                unit_grant.ack <= sel == lbp_pkg::LBP_OP_ACK1;
                unit_grant.lock <= sel == lbp_pkg::LBP_OP_LOCK;
                unit_grant.odd2 <= sel == lbp_pkg::LBP_OP_ODD2;
                unit_grant.cop2 <= sel == lbp_pkg::LBP_OP_COP2;
                unit_grant.cop_new <= sel == lbp_pkg::LBP_OP_COP;
                unit_grant.eu <= sel == lbp_pkg::LBP_OP_EU;
                unit_grant.pf <= sel == lbp_pkg::LBP_OP_PF;
            end
        end
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            stat_reg <= lbp_pkg::STAT_IDLE;
            addr_bit_1 <= 1'b0;
        end else if (ce) begin
            stat_reg <= lbp_pkg::STAT_IDLE;
            if (st_reg == S_IDLE && (halt_pend_reg || shut_pend_reg)) begin
                stat_reg <= lbp_pkg::STAT_HALT;
                addr_bit_1 <= halt_pend_reg ? lbp_pkg::ADDR1_HALT
                                            : lbp_pkg::ADDR1_SHUT;
            end else if (st_reg == S_IDLE
                         && sel != lbp_pkg::LBP_OP_NONE
                         && sel != lbp_pkg::LBP_OP_HOLD) begin
                stat_reg <= op_stat(sel, op_write(sel, unit_wr));
            end else if (st_reg == S_GAP && gap_reg == '0) begin
                stat_reg <= lbp_pkg::STAT_ACK;
            end
        end
    end
    // address drivers float in hold and early in the second ack
    assign upper_byte_enable_oe = addr_oe;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            addr_oe <= 1'b0;
        end else if (ce) begin
            if (st_reg == S_HOLD || st_reg == S_POSTW
                || (st_reg == S_IDLE && sel == lbp_pkg::LBP_OP_HOLD)) begin
                addr_oe <= 1'b0;
            end else if (st_reg == S_GAP && gap_reg == '0) begin
                addr_oe <= 1'b0;
            end else if (op_reg == lbp_pkg::LBP_OP_ACK2
                         && (st_reg == S_TS
                             || (st_reg == S_TC && tc_first_reg
                                 && !done))) begin
                addr_oe <= st_reg == S_TC;
            end else begin
                addr_oe <= 1'b1;
            end
        end
    end
    // locked operations and the first ack hold the exclusive line until done
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            bus_exclusive_n <= 1'b1;
            bus_exclusive_oe <= 1'b0;
        end else if (ce) begin
            bus_exclusive_oe <= !(st_reg == S_HOLD
                                  || st_reg == S_POSTW
                                  || (st_reg == S_GAP && gap_reg == '0)
                                  || (op_reg == lbp_pkg::LBP_OP_ACK2
                                      && (st_reg == S_TS
                                          || (st_reg == S_TC
                                              && tc_first_reg))));
            if (st_reg == S_IDLE) begin
                bus_exclusive_n <= !(sel == lbp_pkg::LBP_OP_ACK1
                                     || sel == lbp_pkg::LBP_OP_LOCK);
            end else if (done) begin
                bus_exclusive_n <= 1'b1;
            end else if (st_reg == S_TC
                         && op_reg == lbp_pkg::LBP_OP_ACK1) begin
                bus_exclusive_n <= 1'b0;
            end
        end
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            bus_grant_out <= 1'b0;
            halted <= 1'b0;
            shut_down <= 1'b0;
        end else if (ce) begin
            bus_grant_out <= (st_reg == S_POSTW)
                             || (st_reg == S_HOLD && hold_s)
                             || (st_reg == S_IDLE
                                 && sel == lbp_pkg::LBP_OP_HOLD
                                 && !halt_pend_reg
                                 && !shut_pend_reg);
            halted <= halt_reg;
            shut_down <= shut_reg;
        end
    end
endmodule

// >>> verilog/lbp_pkg.sv
package lbp_pkg;

    // processor clocks between the two acknowledge operations
    localparam int ACK_GAP_CLKS = 3;
    // prefetch is held off this many clocks ahead of a data transfer
    localparam int PF_INHIBIT_CLKS = 2;
    // command states of the second acknowledge that ignore ready
    localparam int ACK2_FORCED_WAITS = 1;

    // reset values of synchronised pins, in order:
    // ready_n, nmi, maskable_irq, coproc_operand_req, hold_req
    localparam logic [4:0] PIN_INIT = 5'h10;
    localparam int PIN_READY_N = 4;
    localparam int PIN_NMI = 3;
    localparam int PIN_IRQ = 2;
    localparam int PIN_COP = 1;
    localparam int PIN_HOLD = 0;

    // addr_bit_1 value that marks halt versus shutdown
    localparam logic ADDR1_HALT = 1'h1;
    localparam logic ADDR1_SHUT = 1'h0;

    typedef enum {
        LBP_OP_NONE, LBP_OP_ACK1, LBP_OP_ACK2, LBP_OP_LOCK,
        LBP_OP_ODD2, LBP_OP_COP2, LBP_OP_HOLD, LBP_OP_COP,
        LBP_OP_EU, LBP_OP_PF
    } lbp_op_type;

    // requests raised by internal units
    typedef struct packed {
        logic ack;
        logic lock;
        logic odd2;
        logic cop2;
        logic eu;
        logic pf;
    } lbp_req_type;

    // direction of each data requester, high for write
    typedef struct packed {
        logic lock;
        logic odd2;
        logic cop2;
        logic cop_new;
        logic eu;
    } lbp_wr_type;

    // one-cycle grant to the unit whose operation starts
    typedef struct packed {
        logic ack;
        logic lock;
        logic odd2;
        logic cop2;
        logic cop_new;
        logic eu;
        logic pf;
    } lbp_grant_type;

    // bus-cycle definition lines
    typedef struct packed {
        logic s1_n;
        logic s0_n;
        logic cod_n;
        logic mio;
    } lbp_stat_type;

    localparam lbp_stat_type STAT_IDLE = 4'hF;
    localparam lbp_stat_type STAT_HALT = 4'h1;
    localparam lbp_stat_type STAT_ACK = 4'h0;
    localparam lbp_stat_type STAT_CODE = 4'hB;
    localparam lbp_stat_type STAT_DRD = 4'h9;
    localparam lbp_stat_type STAT_DWR = 4'h5;

endpackage

// >>> verilog/lbp_sync.sv
module lbp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // clocking
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ce,
    // pins and filtered levels
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    if (WIDTH < 1) begin : g_bad_width
        $error("lbp_sync needs at least one bit");
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
        end else if (ce) begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a change is taken only once the last two stages agree
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            q <= INIT;
        end else if (ce) begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    q[i] <= s3_reg[i];
                end
            end
        end
    end

endmodule
